// File: rtl/cmcr_pkg.sv
/*
 Constants, register map and carrier types of the clock multiplier control bank.
 Assumes a single 10 MHz device clock and a host on the serial register port.
*/
// Function
// - Free-run bit set routes reference oscillator onto input two path; clear disables.
// - Output force-on bit overrides calibration squelch, keeping outputs driven.
// - Force-on clear keeps outputs squelched until internal calibration has happened.
// - Force-on set drives outputs before calibration, frequency possibly wrong.
// - Bypass bit set sends selected input straight to output buffers, else PLL.
// - Bypassed clocks are never delivered on outputs configured for CMOS.
// - First-priority field bits 1:0 pick input one (00) or two (01); others reserved.
// - Second-priority field bits 3:2 pick input one (00) or two (01); others reserved.
// - Mode register: bypass bit 1, force-on bit 5, free-run bit 6, rest read-only.
// - Squelch-during-cal bit 0 keeps outputs on during calibration, 1 disables them.
// - Force-holdover bit overrides every input selection and ignores input quality.
package cmcr_pkg;
    localparam logic [7:0] A_MODE     = 8'h00;
    localparam logic [7:0] A_PRIO     = 8'h01;
    localparam logic [7:0] A_HOLD     = 8'h03;
    localparam logic [7:0] A_ACTIVE   = 8'h80;
    localparam logic [7:0] A_LOSS     = 8'h81;
    localparam logic [7:0] A_HVALID   = 8'h82;
    localparam logic [7:0] A_LOSS_STK = 8'h83;
    localparam logic [7:0] A_FREQ_STK = 8'h84;
    localparam logic [7:0] A_ID_HI    = 8'h86;
    localparam logic [7:0] A_ID_LO    = 8'h87;
    localparam logic [7:0] A_CALIB    = 8'h88;

    localparam logic [7:0] A_OUT2_DIV_MID = 8'h23;
    localparam logic [7:0] A_OUT2_DIV_LO  = 8'h24;
    localparam logic [7:0] A_FB_DIV_HI    = 8'h28;
    localparam logic [7:0] A_FB_DIV_MID   = 8'h29;
    localparam logic [7:0] A_FB_DIV_LO    = 8'h2A;
    localparam logic [7:0] A_IN1_DIV_HI   = 8'h2B;
    localparam logic [7:0] A_IN1_DIV_MID  = 8'h2C;
    localparam logic [7:0] A_IN1_DIV_LO   = 8'h2D;
    localparam logic [7:0] A_IN2_DIV_HI   = 8'h2E;
    localparam logic [7:0] A_IN2_DIV_MID  = 8'h2F;
    localparam logic [7:0] A_IN2_DIV_LO   = 8'h30;
    localparam logic [7:0] A_RATE_SEL     = 8'h37;
    localparam logic [7:0] A_QUICK_LOCK   = 8'h89;
    localparam logic [7:0] A_LOSS_EN_HI   = 8'h8A;
    localparam logic [7:0] A_MON_EN       = 8'h8B;
    localparam logic [7:0] A_OUT1_SKEW    = 8'h8E;
    localparam logic [7:0] A_OUT2_SKEW    = 8'h8F;

    localparam logic [7:0] RST_MODE = 8'h14;
    localparam logic [7:0] RST_PRIO = 8'hE4;
    localparam logic [7:0] RST_HOLD = 8'h05;
    localparam logic [7:0] MSK_MODE = 8'h62;
    localparam logic [7:0] MSK_PRIO = 8'h0F;
    localparam logic [7:0] MSK_HOLD = 8'h30;
    localparam logic [7:0] MSK_STK  = 8'h07;
    // Idle levels of {sclk, cs_n, mosi}
    localparam logic [2:0] PIN_IDLE = 3'h2;

    localparam int B_BYPASS   = 1;
    localparam int B_FORCE_ON = 5;
    localparam int B_FREE_RUN = 6;
    localparam int B_SQ_CAL   = 4;
    localparam int B_HOLDOVER = 5;
    localparam int B_CAL_GO   = 6;
    localparam int B_HVALID   = 7;

    localparam logic [1:0] SEL_IN1 = 2'h0;
    localparam logic [1:0] SEL_IN2 = 2'h1;

    localparam int GP_SLOTS = 17;

    typedef enum logic [2:0] {
        CMCR_ST_ADDR = 3'b001,
        CMCR_ST_CMD  = 3'b010,
        CMCR_ST_DATA = 3'b100
    } cmcr_state_t;

    typedef struct packed {
        logic [2:0] loss;
        logic [2:0] freq_lock;
        logic [1:0] input_bad;
        logic [1:0] out_is_cmos;
        logic       hold_valid;
        logic       cal_busy;
        logic       cal_success;
    } cmcr_stat_t;

    typedef struct packed {
        logic       ref_to_input_two;
        logic [1:0] output_clock_en;
        logic [1:0] bypass_on_output;
        logic       pll_bypass;
        logic       holdover;
        logic [1:0] active_input;
        logic       cal_start;
    } cmcr_ctrl_t;
endpackage : cmcr_pkg

// File: rtl/cmcr_top.sv
/*
 Control register bank with serial slave port (mode 0: addr, cmd, data bytes).
 Assumes status inputs are on clk; serial pins are asynchronous and synchronised.
*/
`timescale 1ns/1ps
`default_nettype none
module cmcr_top
    import cmcr_pkg::*;
#(
    parameter logic [11:0] PART_ID  = 12'hABC,
    parameter logic [3:0]  REV_ID   = 4'h1,
    parameter logic [1:0]  GRADE_ID = 2'h0
) (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       spi_sclk,
    input  wire logic       spi_cs_n,
    input  wire logic       spi_mosi,
    output var  logic       spi_miso_o,
    output var  logic       spi_miso_oe,
    input  wire cmcr_stat_t stat,
    output var  cmcr_ctrl_t ctrl
);
    // Arbitrary identity values above

    logic [2:0]  pin_s1_ff, nxt_pin_s1;
    logic [2:0]  sync_ff, nxt_sync;
    logic        sclk_d_ff, nxt_sclk_d;
    cmcr_state_t st_ff, nxt_st;
    logic [2:0]  bit_ff, nxt_bit;
    logic [7:0]  sh_ff, nxt_sh;
    logic [7:0]  addr_ff, nxt_addr;
    logic        rd_ff, nxt_rd;
    logic [7:0]  out_ff, nxt_out;
    logic        miso_ff, nxt_miso;
    logic        oe_ff, nxt_oe;

    logic [7:0]  mode_ff, nxt_mode;
    logic [7:0]  prio_ff, nxt_prio;
    logic [7:0]  hold_ff, nxt_hold;
    logic [2:0]  loss_stk_ff, nxt_loss_stk;
    logic [2:0]  freq_stk_ff, nxt_freq_stk;
    logic        cal_seen_ff, nxt_cal_seen;
    logic        cal_busy_d_ff, nxt_cal_busy_d;
    logic [7:0]  gp_ff [GP_SLOTS];
    logic [7:0]  nxt_gp [GP_SLOTS];
    cmcr_ctrl_t  nxt_ctrl;

    logic        sclk_s;
    logic        cs_n_s;
    logic        mosi_s;
    logic        rise;
    logic        fall;
    logic        wr_go;
    logic [7:0]  rdata;
    logic [7:0]  wdata;
    logic [5:0]  slot;
    logic [1:0]  pick;

    // Maps an address to a plain storage slot, bit 5 flags a hit
    function automatic logic [5:0] gp_slot(input logic [7:0] a);
        case (a)
            A_OUT2_DIV_MID: gp_slot = {1'b1, 5'h00};
            A_OUT2_DIV_LO:  gp_slot = {1'b1, 5'h01};
            A_FB_DIV_HI:    gp_slot = {1'b1, 5'h02};
            A_FB_DIV_MID:   gp_slot = {1'b1, 5'h03};
            A_FB_DIV_LO:    gp_slot = {1'b1, 5'h04};
            A_IN1_DIV_HI:   gp_slot = {1'b1, 5'h05};
            A_IN1_DIV_MID:  gp_slot = {1'b1, 5'h06};
            A_IN1_DIV_LO:   gp_slot = {1'b1, 5'h07};
            A_IN2_DIV_HI:   gp_slot = {1'b1, 5'h08};
            A_IN2_DIV_MID:  gp_slot = {1'b1, 5'h09};
            A_IN2_DIV_LO:   gp_slot = {1'b1, 5'h0A};
            A_RATE_SEL:     gp_slot = {1'b1, 5'h0B};
            A_QUICK_LOCK:   gp_slot = {1'b1, 5'h0C};
            A_LOSS_EN_HI:   gp_slot = {1'b1, 5'h0D};
            A_MON_EN:       gp_slot = {1'b1, 5'h0E};
            A_OUT1_SKEW:    gp_slot = {1'b1, 5'h0F};
            A_OUT2_SKEW:    gp_slot = {1'b1, 5'h10};
            default: gp_slot = 6'h00;
        endcase
    endfunction : gp_slot

    // Input number chosen by a priority code, 0 when reserved or bad
    function automatic logic [1:0] ranked(input logic [1:0] code, input logic [1:0] bad);
        if (code == SEL_IN1 && !bad[0]) begin
            ranked = 2'h1;
        end else if (code == SEL_IN2 && !bad[1]) begin
            ranked = 2'h2;
        end else begin
            ranked = 2'h0;
        end
    endfunction : ranked

    // Two-stage pin synchronisers, idle levels at reset
    always_comb begin
        nxt_pin_s1 = {spi_sclk, spi_cs_n, spi_mosi};
        nxt_sync   = pin_s1_ff;
        nxt_sclk_d = sync_ff[2];
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_s1_ff <= PIN_IDLE;
            sync_ff   <= PIN_IDLE;
            sclk_d_ff <= 1'b0;
        end else begin
            pin_s1_ff <= nxt_pin_s1;
            sync_ff   <= nxt_sync;
            sclk_d_ff <= nxt_sclk_d;
        end
    end

    assign sclk_s = sync_ff[2];
    assign cs_n_s = sync_ff[1];
    assign mosi_s = sync_ff[0];
    assign rise   = sclk_s & ~sclk_d_ff & ~cs_n_s;
    assign fall   = ~sclk_s & sclk_d_ff & ~cs_n_s;
    assign wdata  = {sh_ff[6:0], mosi_s};
    assign wr_go  = rise && st_ff == CMCR_ST_DATA && bit_ff == 3'h7 && !rd_ff;
    assign slot   = gp_slot(addr_ff);

    // Read mux; reserved bits return their reset values
    always_comb begin
        rdata = 8'h00;
        unique case (addr_ff)
            A_MODE:     rdata = (RST_MODE & ~MSK_MODE) | (mode_ff & MSK_MODE);
            A_PRIO:     rdata = (RST_PRIO & ~MSK_PRIO) | (prio_ff & MSK_PRIO);
            A_HOLD:     rdata = (RST_HOLD & ~MSK_HOLD) | (hold_ff & MSK_HOLD);
            A_ACTIVE:   rdata = {6'h00, ctrl.active_input};
            A_LOSS:     rdata = {5'h00, stat.loss};
            A_HVALID:   rdata = {stat.hold_valid, 4'h0, stat.freq_lock};
            A_LOSS_STK: rdata = {5'h00, loss_stk_ff};
            A_FREQ_STK: rdata = {5'h00, freq_stk_ff};
            A_ID_HI:    rdata = PART_ID[11:4];
            A_ID_LO:    rdata = {PART_ID[3:0], REV_ID};
            A_CALIB:    rdata = {1'b0, stat.cal_busy, 4'h0, GRADE_ID};
            default:    rdata = slot[5] ? gp_ff[slot[4:0]] : 8'h00;
        endcase
    end

    // Serial slave framing
    always_comb begin
        nxt_st   = st_ff;
        nxt_bit  = bit_ff;
        nxt_sh   = sh_ff;
        nxt_addr = addr_ff;
        nxt_rd   = rd_ff;
        nxt_out  = out_ff;
        nxt_miso = miso_ff;
        nxt_oe   = ~cs_n_s;
        if (cs_n_s) begin
            nxt_st   = CMCR_ST_ADDR;
            nxt_bit  = 3'h0;
            nxt_miso = 1'b0;
        end else if (rise) begin
            nxt_sh  = wdata;
            nxt_bit = bit_ff + 3'h1;
            if (bit_ff == 3'h7) begin
                unique case (st_ff)
                    CMCR_ST_ADDR: begin
                        nxt_addr = wdata;
                        nxt_st   = CMCR_ST_CMD;
                    end
                    CMCR_ST_CMD: begin
                        nxt_rd  = wdata[7];
                        nxt_out = rdata;
                        nxt_st  = CMCR_ST_DATA;
                    end
                    CMCR_ST_DATA: begin
                        nxt_addr = addr_ff + 8'h01;
                        nxt_st   = CMCR_ST_CMD;
                    end
                    default: nxt_st = CMCR_ST_ADDR;
                endcase
            end
        end else if (fall && st_ff == CMCR_ST_DATA) begin
            nxt_miso = out_ff[7];
            nxt_out  = {out_ff[6:0], 1'b0};
        end
    end

    // Framing registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff   <= CMCR_ST_ADDR;
            bit_ff  <= 3'h0;
            sh_ff   <= 8'h00;
            addr_ff <= 8'h00;
            rd_ff   <= 1'b0;
            out_ff  <= 8'h00;
            miso_ff <= 1'b0;
            oe_ff   <= 1'b0;
        end else begin
            st_ff   <= nxt_st;
            bit_ff  <= nxt_bit;
            sh_ff   <= nxt_sh;
            addr_ff <= nxt_addr;
            rd_ff   <= nxt_rd;
            out_ff  <= nxt_out;
            miso_ff <= nxt_miso;
            oe_ff   <= nxt_oe;
        end
    end

    // Register writes and sticky flags
    always_comb begin
        nxt_mode     = mode_ff;
        nxt_prio     = prio_ff;
        nxt_hold     = hold_ff;
        nxt_loss_stk = loss_stk_ff;
        nxt_freq_stk = freq_stk_ff;
        for (int i = 0; i < GP_SLOTS; i++) begin
            nxt_gp[i] = gp_ff[i];
        end
        if (wr_go) begin
            unique case (addr_ff)
                A_MODE: nxt_mode = (RST_MODE & ~MSK_MODE) | (wdata & MSK_MODE);
                A_PRIO: nxt_prio = (RST_PRIO & ~MSK_PRIO) | (wdata & MSK_PRIO);
                A_HOLD: nxt_hold = (RST_HOLD & ~MSK_HOLD) | (wdata & MSK_HOLD);
                A_LOSS_STK: nxt_loss_stk = loss_stk_ff & wdata[2:0];
                A_FREQ_STK: nxt_freq_stk = freq_stk_ff & wdata[2:0];
                default: begin
                    if (slot[5]) begin
                        nxt_gp[slot[4:0]] = wdata;
                    end
                end
            endcase
        end
        // Set wins over a clearing write
        nxt_loss_stk = nxt_loss_stk | stat.loss;
        nxt_freq_stk = nxt_freq_stk | stat.freq_lock;
    end

    // Register bank state
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_ff     <= RST_MODE;
            prio_ff     <= RST_PRIO;
            hold_ff     <= RST_HOLD;
            loss_stk_ff <= 3'h0;
            freq_stk_ff <= 3'h0;
            for (int i = 0; i < GP_SLOTS; i++) begin
                gp_ff[i] <= 8'h00;
            end
        end else begin
            mode_ff     <= nxt_mode;
            prio_ff     <= nxt_prio;
            hold_ff     <= nxt_hold;
            loss_stk_ff <= nxt_loss_stk;
            freq_stk_ff <= nxt_freq_stk;
            for (int i = 0; i < GP_SLOTS; i++) begin
                gp_ff[i] <= nxt_gp[i];
            end
        end
    end

    // Clock path control
    always_comb begin
        nxt_cal_busy_d = stat.cal_busy;
        nxt_cal_seen   = cal_seen_ff | (cal_busy_d_ff & ~stat.cal_busy);
        pick = ranked(prio_ff[1:0], stat.input_bad);
        if (pick == 2'h0) begin
            pick = ranked(prio_ff[3:2], stat.input_bad);
        end
        nxt_ctrl = '0;
        nxt_ctrl.ref_to_input_two = mode_ff[B_FREE_RUN];
        nxt_ctrl.holdover = hold_ff[B_HOLDOVER];
        nxt_ctrl.active_input = hold_ff[B_HOLDOVER] ? 2'h0 : pick;
        nxt_ctrl.pll_bypass = mode_ff[B_BYPASS];
        for (int i = 0; i < 2; i++) begin
            nxt_ctrl.bypass_on_output[i] = mode_ff[B_BYPASS] & ~stat.out_is_cmos[i];
        end
        if (mode_ff[B_FORCE_ON]) begin
            nxt_ctrl.output_clock_en = 2'h3;
        end else if (!nxt_cal_seen) begin
            nxt_ctrl.output_clock_en = 2'h0;
        end else if (hold_ff[B_SQ_CAL] && (stat.cal_busy || !stat.cal_success)) begin
            nxt_ctrl.output_clock_en = 2'h0;
        end else begin
            nxt_ctrl.output_clock_en = 2'h3;
        end
        nxt_ctrl.cal_start = wr_go && addr_ff == A_CALIB && wdata[B_CAL_GO];
    end

    // Clock path state
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cal_seen_ff   <= 1'b0;
            cal_busy_d_ff <= 1'b0;
            ctrl          <= '0;
        end else begin
            cal_seen_ff   <= nxt_cal_seen;
            cal_busy_d_ff <= nxt_cal_busy_d;
            ctrl          <= nxt_ctrl;
        end
    end

    assign spi_miso_o  = miso_ff;
    assign spi_miso_oe = oe_ff;
endmodule : cmcr_top
`default_nettype wire

// File: tb/cmcr_top_props.sv
/* Port assertions of the control bank.
   Bound to cmcr_top; sees only its ports, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module cmcr_top_props
    import cmcr_pkg::*;
(
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic       spi_sclk,
    input wire logic       spi_cs_n,
    input wire logic       spi_mosi,
    input wire logic       spi_miso_o,
    input wire logic       spi_miso_oe,
    input wire cmcr_stat_t stat,
    input wire cmcr_ctrl_t ctrl
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_cs_idle;
        spi_cs_n [*6];
    endsequence
    sequence s_cs_start;
        $fell(spi_cs_n);
    endsequence
    property p_bypass_cmos;
        ctrl.bypass_on_output[0] |-> ctrl.pll_bypass && !$past(stat.out_is_cmos[0]);
    endproperty
    a_bypass_cmos: assert property (p_bypass_cmos) else $error("bypass on cmos output");
    property p_bypass_out;
        ctrl.pll_bypass && !$past(stat.out_is_cmos[1]) |-> ctrl.bypass_on_output[1];
    endproperty
    a_bypass_out: assert property (p_bypass_out) else $error("bypass path missing");
    property p_hold_sel;
        ctrl.holdover |-> ctrl.active_input == 2'h0;
    endproperty
    a_hold_sel: assert property (p_hold_sel) else $error("input active in holdover");
    property p_sel_in1;
        ctrl.active_input[0] |-> !$past(stat.input_bad[0]) && !ctrl.active_input[1];
    endproperty
    a_sel_in1: assert property (p_sel_in1) else $error("bad input one chosen");
    property p_sel_in2;
        ctrl.active_input[1] |-> !$past(stat.input_bad[1]);
    endproperty
    a_sel_in2: assert property (p_sel_in2) else $error("bad input two chosen");
    property p_en_pair;
        ctrl.output_clock_en[0] == ctrl.output_clock_en[1];
    endproperty
    a_en_pair: assert property (p_en_pair) else $error("outputs enabled apart");
    property p_free_run_wr;
        $changed(ctrl.ref_to_input_two) |-> !$past(spi_cs_n, 5);
    endproperty
    a_free_run_wr: assert property (p_free_run_wr) else $error("free run moved idle");
    property p_oe_idle;
        s_cs_idle |-> !spi_miso_oe && !spi_miso_o;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("data out driven idle");
    property p_oe_on;
        s_cs_start |-> ##[1:5] spi_miso_oe;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("data out not enabled");
    property p_cal_pulse;
        ctrl.cal_start |=> !ctrl.cal_start;
    endproperty
    a_cal_pulse: assert property (p_cal_pulse) else $error("calibration start too long");
endmodule : cmcr_top_props
bind cmcr_top cmcr_top_props u_props (.clk(clk), .arst_n(arst_n), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o),
    .spi_miso_oe(spi_miso_oe), .stat(stat), .ctrl(ctrl));
`default_nettype wire

// File: tb/cmcr_host.sv
/* Serial host model: one address, command, data frame per call.
   Assumes clk is the device clock; drives pins on its falling edge. */
`timescale 1ns/1ps
`default_nettype none
module cmcr_host (
    input  wire logic clk,
    input  wire logic miso,
    output var  logic sclk,
    output var  logic cs_n,
    output var  logic mosi
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // Reserved command bits are sent as zeros; data bits are the caller's
    task automatic xfer(input logic [7:0] a, input logic r, input logic [7:0] wd,
                        output logic [7:0] q);
        logic [23:0] word;
        word = {a, r, 7'h00, wd};
        q = 8'h00;
        @(negedge clk);
        cs_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            mosi = word[i];
            repeat (6) @(negedge clk);
            if (i < 8) begin
                q[i] = miso;
            end
            sclk = 1'b1;
            repeat (6) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (6) @(negedge clk);
        cs_n = 1'b1;
        mosi = ~mosi;
        repeat (6) @(negedge clk);
    endtask : xfer
endmodule : cmcr_host
`default_nettype wire

// File: tb/cmcr_top_test.sv
/* Self-checking bench of the control bank over its serial port.
   Assumes the bound checker and the host model beside it. */
`timescale 1ns/1ps
`default_nettype none
module cmcr_top_test;
    import cmcr_pkg::*;
    logic       clk = 1'b0;
    logic       arst_n;
    cmcr_stat_t stat;
    cmcr_ctrl_t ctrl;
    wire logic  sclk;
    wire logic  cs_n;
    wire logic  mosi;
    wire logic  miso_o;
    wire logic  miso_oe;
    wire logic  miso_line;
    int         miscompares = 0;
    int         total_checks = 0;
    int         cal_pulses = 0;
    logic [7:0] pv [6] = '{8'hE4, 8'hE1, 8'hE1, 8'hE6, 8'hEB, 8'hE4};
    logic [1:0] bad [6] = '{2'h0, 2'h0, 2'h2, 2'h0, 2'h0, 2'h3};
    logic [1:0] act [6] = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h0, 2'h0};
    assign miso_line = miso_oe ? miso_o : ~miso_o;
    always #50 clk = ~clk;
    always @(negedge clk) begin
        if (ctrl.cal_start === 1'b1) begin
            cal_pulses++;
        end
    end
    cmcr_top DUT (.clk(clk), .arst_n(arst_n), .spi_sclk(sclk), .spi_cs_n(cs_n),
        .spi_mosi(mosi), .spi_miso_o(miso_o), .spi_miso_oe(miso_oe), .stat(stat), .ctrl(ctrl));
    cmcr_host u_host (.clk(clk), .miso(miso_line), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));
    task automatic test_done;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        u_host.xfer(a, 1'b0, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        u_host.xfer(a, 1'b1, 8'h00, q);
        chk(q, e);
    endtask : rd
    task automatic stat_wait;
        repeat (3) @(negedge clk);
    endtask : stat_wait
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        test_done();
    end
    initial begin
        stat = '0;
        stat.out_is_cmos = 2'h2;
        arst_n = 1'b0;
        repeat (6) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        rd(A_MODE, RST_MODE);
        rd(A_PRIO, RST_PRIO);
        rd(A_HOLD, RST_HOLD);
        chk(8'(ctrl.output_clock_en), 8'h00);
        wr(A_MODE, 8'hFF);
        rd(A_MODE, 8'h76);
        chk(8'(ctrl.ref_to_input_two), 8'h01);
        chk(8'(ctrl.pll_bypass), 8'h01);
        chk(8'(ctrl.bypass_on_output), 8'h01);
        chk(8'(ctrl.output_clock_en), 8'h03);
        stat.out_is_cmos = 2'h1;
        stat_wait();
        chk(8'(ctrl.bypass_on_output), 8'h02);
        stat.out_is_cmos = 2'h2;
        wr(A_MODE, RST_MODE);
        chk(8'(ctrl.ref_to_input_two), 8'h00);
        chk(8'(ctrl.pll_bypass), 8'h00);
        chk(8'(ctrl.output_clock_en), 8'h00);
        for (int k = 0; k < 6; k++) begin
            stat.input_bad = bad[k];
            wr(A_PRIO, pv[k]);
            chk(8'(ctrl.active_input), 8'(act[k]));
        end
        stat.input_bad = 2'h0;
        wr(A_PRIO, 8'h15);
        rd(A_PRIO, 8'hE5);
        wr(A_HOLD, 8'h25);
        chk(8'(ctrl.holdover), 8'h01);
        chk(8'(ctrl.active_input), 8'h00);
        rd(A_HOLD, 8'h25);
        wr(A_HOLD, RST_HOLD);
        chk(8'(ctrl.active_input), 8'h02);
        stat.cal_busy = 1'b1;
        stat_wait();
        chk(8'(ctrl.output_clock_en), 8'h00);
        stat.cal_busy = 1'b0;
        stat_wait();
        chk(8'(ctrl.output_clock_en), 8'h03);
        wr(A_HOLD, 8'h15);
        chk(8'(ctrl.output_clock_en), 8'h00);
        stat.cal_success = 1'b1;
        stat_wait();
        chk(8'(ctrl.output_clock_en), 8'h03);
        stat.cal_busy = 1'b1;
        stat_wait();
        chk(8'(ctrl.output_clock_en), 8'h00);
        wr(A_MODE, 8'h34);
        chk(8'(ctrl.output_clock_en), 8'h03);
        stat.cal_busy = 1'b0;
        rd(8'h50, 8'h00);
        wr(A_ID_HI, 8'h00);
        rd(A_ID_HI, 8'hAB);
        wr(A_OUT2_SKEW, 8'hA5);
        rd(A_OUT2_SKEW, 8'hA5);
        rd(A_ACTIVE, 8'h02);
        stat.loss = 3'h5;
        stat.hold_valid = 1'b1;
        stat_wait();
        stat.loss = 3'h0;
        rd(A_HVALID, 8'h80);
        rd(A_LOSS_STK, 8'h05);
        wr(A_LOSS_STK, 8'h04);
        rd(A_LOSS_STK, 8'h04);
        wr(A_CALIB, 8'h00);
        wr(A_CALIB, 8'h40);
        chk(8'(cal_pulses), 8'h01);
        rd(A_CALIB, 8'h00);
        test_done();
    end
endmodule : cmcr_top_test
`default_nettype wire
